// *** hdl/scf_soft_clear_and_flag_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module scf_soft_clear_and_flag_status
   import scf_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic clr_wr_in,
   input wire logic [SCF_DATA_W-1:0] clr_wdata_in,
   input wire logic flag_rd_in,
   output logic [SCF_DATA_W-1:0] flag_rdata_out,
   input wire logic queue_empty_rd_in,
   output logic [SCF_DATA_W-1:0] queue_empty_word_out,
   input wire logic alu_busy_in,
   input wire logic queue_is_empty_in,
   input wire logic queue_overflow_in,
   input wire logic queue_is_full_in,
   input wire logic queue_word_out_in,
   input wire logic lut_stream_mode_in,
   input wire logic die_temp_on_second_channel_in,
   input wire logic die_temp_alarm_high_in,
   input wire logic die_temp_alarm_low_in,
   input wire logic ch2_current_over_high_in,
   input wire logic ch2_current_over_low_in,
   input wire logic ch2_temp_over_high_in,
   input wire logic ch2_temp_over_low_in,
   input wire logic ch1_current_over_high_in,
   input wire logic ch1_current_over_low_in,
   input wire logic ch1_temp_over_high_in,
   input wire logic ch1_temp_over_low_in,
   output logic complete_reset_out,
   output logic alarm_threshold_clear_out,
   output logic averaging_memory_clear_out,
   output logic sample_queue_clear_out,
   output logic ch2_converter_clear_out,
   output logic ch1_converter_clear_out
);

   logic complete_reset_arm_q, complete_reset_arm_d;
   logic complete_reset_q, complete_reset_d;
   logic alarm_clr_q, avg_clr_q, queue_clr_q, ch2_clr_q, ch1_clr_q;
   logic restart_q, restart_d;
   logic overflow_q, overflow_d;
   logic [SCF_ALARM_W-1:0] alarm_q, alarm_d;
   logic [SCF_DATA_W-1:0] flag_rdata_q, empty_word_q;

   // write decode of the software clear control register
   wire wr_cmd = clr_wr_in & clr_wdata_in[SCF_CLR_COMPLETE_RESET_CMD];
   wire wr_arm = clr_wr_in & clr_wdata_in[SCF_CLR_COMPLETE_RESET_ARM];
   wire fire_reset = wr_cmd & complete_reset_arm_q;
   // any write re-evaluates the arm, so only the write just before the command arms it
   assign complete_reset_arm_d = clr_wr_in ? (wr_arm & ~wr_cmd) : complete_reset_arm_q;
   assign complete_reset_d = fire_reset;

   // one-cycle clear strobes, one per written bit
   wire wr_alarm_clr = clr_wr_in & clr_wdata_in[SCF_CLR_ALARM_THRESHOLD];
   wire wr_avg_clr = clr_wr_in & clr_wdata_in[SCF_CLR_AVERAGING_MEMORY];
   wire wr_queue_clr = clr_wr_in & clr_wdata_in[SCF_CLR_SAMPLE_QUEUE];
   wire wr_ch2_clr = clr_wr_in & clr_wdata_in[SCF_CLR_CH2_CONVERTER];
   wire wr_ch1_clr = clr_wr_in & clr_wdata_in[SCF_CLR_CH1_CONVERTER];

   // alarm flag sources; die sensor replaces channel 2 current in that mode
   wire [SCF_ALARM_W-1:0] alarm_set = {
      die_temp_on_second_channel_in ? die_temp_alarm_high_in : ch2_current_over_high_in,
      die_temp_on_second_channel_in ? die_temp_alarm_low_in : ch2_current_over_low_in,
      ch2_temp_over_high_in,
      ch2_temp_over_low_in,
      ch1_current_over_high_in,
      ch1_current_over_low_in,
      ch1_temp_over_high_in,
      ch1_temp_over_low_in
   };
   // read and alarm clear both drop flags, a same-cycle event wins
   wire alarm_drop = flag_rd_in | alarm_clr_q | complete_reset_q;
   assign alarm_d = alarm_set | (alarm_q & {SCF_ALARM_W{~alarm_drop}});

   assign restart_d = complete_reset_q | (restart_q & ~flag_rd_in);

   wire ovf_adc = queue_overflow_in | (overflow_q & ~flag_rd_in);
   wire ovf_lut = queue_is_full_in | (overflow_q & ~queue_word_out_in);
   assign overflow_d = lut_stream_mode_in ? ovf_lut : ovf_adc;

   // live view of the status flag register
   wire [SCF_DATA_W-1:0] flag_value = {
      SCF_RSVD_VALUE,
      alu_busy_in,
      restart_q,
      queue_is_empty_in,
      overflow_q,
      alarm_q
   };
   wire [SCF_DATA_W-1:0] empty_word = {SCF_EMPTY_QUEUE_TAG,
      flag_value[SCF_FLG_RSVD_LSB-1:0]};

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         complete_reset_arm_q <= SCF_ARM_RST;
         complete_reset_q <= SCF_PULSE_RST;
         alarm_clr_q <= SCF_PULSE_RST;
         avg_clr_q <= SCF_PULSE_RST;
         queue_clr_q <= SCF_PULSE_RST;
         ch2_clr_q <= SCF_PULSE_RST;
         ch1_clr_q <= SCF_PULSE_RST;
      end else begin
         complete_reset_arm_q <= complete_reset_arm_d;
         complete_reset_q <= complete_reset_d;
         alarm_clr_q <= wr_alarm_clr;
         avg_clr_q <= wr_avg_clr;
         queue_clr_q <= wr_queue_clr;
         ch2_clr_q <= wr_ch2_clr;
         ch1_clr_q <= wr_ch1_clr;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         restart_q <= SCF_RESTART_RST;
         overflow_q <= SCF_OVERFLOW_RST;
         alarm_q <= SCF_ALARM_RST;
      end else begin
         restart_q <= restart_d;
         overflow_q <= overflow_d;
         alarm_q <= alarm_d;
      end
   end

   // read data is captured so the host sees the value from before the clear
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         flag_rdata_q <= SCF_WORD_RST;
         empty_word_q <= SCF_WORD_RST;
      end else begin
         if (flag_rd_in) begin
            flag_rdata_q <= flag_value;
         end
         if (queue_empty_rd_in) begin
            empty_word_q <= empty_word;
         end
      end
   end

   assign flag_rdata_out = flag_rdata_q;
   assign queue_empty_word_out = empty_word_q;
   assign complete_reset_out = complete_reset_q;
   assign alarm_threshold_clear_out = alarm_clr_q;
   assign averaging_memory_clear_out = avg_clr_q;
   assign sample_queue_clear_out = queue_clr_q;
   assign ch2_converter_clear_out = ch2_clr_q;
   assign ch1_converter_clear_out = ch1_clr_q;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);

   sequence s_arm_write;
      clr_wr_in && clr_wdata_in[SCF_CLR_COMPLETE_RESET_ARM]
         && !clr_wdata_in[SCF_CLR_COMPLETE_RESET_CMD];
   endsequence

   sequence s_cmd_write;
      clr_wr_in && clr_wdata_in[SCF_CLR_COMPLETE_RESET_CMD];
   endsequence

   property p_armed_reset;
      s_arm_write ##1 !clr_wr_in ##1 s_cmd_write |=> complete_reset_out ##1 restart_q;
   endproperty
   a_armed_reset: assert property (p_armed_reset)
      else $error("armed full reset did not fire or set restart");

   property p_unarmed_reset;
      s_cmd_write and !complete_reset_arm_q |=> !complete_reset_out;
   endproperty
   a_unarmed_reset: assert property (p_unarmed_reset)
      else $error("full reset fired without arming");

   property p_arm_then_idle;
      s_arm_write ##1 !clr_wr_in |-> complete_reset_arm_q;
   endproperty
   a_arm_then_idle: assert property (p_arm_then_idle)
      else $error("arm bit not held after arming write");

   property p_clear_pulses;
      clr_wr_in |=> (alarm_threshold_clear_out == $past(clr_wdata_in[SCF_CLR_ALARM_THRESHOLD]))
         && (ch1_converter_clear_out == $past(clr_wdata_in[SCF_CLR_CH1_CONVERTER]))
         && (ch2_converter_clear_out == $past(clr_wdata_in[SCF_CLR_CH2_CONVERTER]))
         && (sample_queue_clear_out == $past(clr_wdata_in[SCF_CLR_SAMPLE_QUEUE]));
   endproperty
   a_clear_pulses: assert property (p_clear_pulses)
      else $error("clear pulse does not match written bit");

   property p_alarm_clear_flags;
      alarm_threshold_clear_out && (alarm_set == 8'h00) |=> alarm_q == 8'h00;
   endproperty
   a_alarm_clear_flags: assert property (p_alarm_clear_flags)
      else $error("alarm flags survived alarm clear");

   property p_read_snapshot;
      flag_rd_in |=> flag_rdata_out[SCF_FLG_ALU_BUSY] == $past(alu_busy_in)
         && flag_rdata_out[SCF_FLG_QUEUE_EMPTY] == $past(queue_is_empty_in);
   endproperty
   a_read_snapshot: assert property (p_read_snapshot)
      else $error("status read did not capture busy or empty");

   property p_read_clears;
      flag_rd_in && !ch1_temp_over_high_in && !alarm_clr_q |=> !alarm_q[SCF_FLG_CH1_TEMP_HIGH];
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("flag not cleared by status read");

   property p_set_wins;
      flag_rd_in && ch1_current_over_low_in |=> alarm_q[SCF_FLG_CH1_CURRENT_LOW] ##1
         flag_rdata_out[SCF_FLG_CH1_CURRENT_LOW] || !$past(flag_rd_in);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost when coinciding with read");

   property p_die_temp_source;
      die_temp_on_second_channel_in && die_temp_alarm_high_in
         |=> alarm_q[SCF_FLG_CH2_CURRENT_HIGH];
   endproperty
   a_die_temp_source: assert property (p_die_temp_source)
      else $error("die temperature alarm not routed to channel 2 flag");

   property p_lut_full;
      lut_stream_mode_in && queue_is_full_in |=> overflow_q;
   endproperty
   a_lut_full: assert property (p_lut_full)
      else $error("full queue not shown in streaming mode");

   property p_adc_overflow;
      !lut_stream_mode_in && queue_overflow_in |=> overflow_q;
   endproperty
   a_adc_overflow: assert property (p_adc_overflow)
      else $error("overflow not flagged in monitoring mode");

   property p_empty_tag;
      queue_empty_rd_in |=>
         queue_empty_word_out[SCF_DATA_W-1:SCF_FLG_RSVD_LSB] == SCF_EMPTY_QUEUE_TAG
         && queue_empty_word_out[SCF_FLG_RESTART] == $past(restart_q);
   endproperty
   a_empty_tag: assert property (p_empty_tag)
      else $error("empty queue read word malformed");

   // the command write itself disarms, so a second command needs a fresh arm
   property p_arm_consumed;
      s_cmd_write |=> !complete_reset_arm_q;
   endproperty
   a_arm_consumed: assert property (p_arm_consumed)
      else $error("arm survived a command write");

   property p_avg_pulse;
      clr_wr_in |=>
         averaging_memory_clear_out == $past(clr_wdata_in[SCF_CLR_AVERAGING_MEMORY]);
   endproperty
   a_avg_pulse: assert property (p_avg_pulse)
      else $error("average clear pulse does not match written bit");

   property p_no_write_no_pulse;
      !clr_wr_in |=> !complete_reset_out && !alarm_threshold_clear_out
         && !averaging_memory_clear_out && !sample_queue_clear_out
         && !ch2_converter_clear_out && !ch1_converter_clear_out;
   endproperty
   a_no_write_no_pulse: assert property (p_no_write_no_pulse)
      else $error("clear pulse without a write");

   property p_restart_set;
      complete_reset_out |=> restart_q;
   endproperty
   a_restart_set: assert property (p_restart_set)
      else $error("restart flag not set after full reset");

   property p_restart_clear;
      flag_rd_in && !complete_reset_out |=> !restart_q;
   endproperty
   a_restart_clear: assert property (p_restart_clear)
      else $error("restart flag not cleared by status read");

   property p_ovf_read_clear;
      !lut_stream_mode_in && flag_rd_in && !queue_overflow_in |=> !overflow_q;
   endproperty
   a_ovf_read_clear: assert property (p_ovf_read_clear)
      else $error("overflow not cleared by read in monitoring mode");

   property p_lut_word_out;
      lut_stream_mode_in && queue_word_out_in && !queue_is_full_in |=> !overflow_q;
   endproperty
   a_lut_word_out: assert property (p_lut_word_out)
      else $error("full flag not cleared when a word left the queue");

   // a status read must not drop the full indication in streaming mode
   property p_lut_read_keeps;
      lut_stream_mode_in && overflow_q && !queue_word_out_in |=> overflow_q;
   endproperty
   a_lut_read_keeps: assert property (p_lut_read_keeps)
      else $error("full flag lost without a word leaving");

   property p_ch2_native;
      !die_temp_on_second_channel_in && ch2_current_over_high_in
         |=> alarm_q[SCF_FLG_CH2_CURRENT_HIGH];
   endproperty
   a_ch2_native: assert property (p_ch2_native)
      else $error("channel 2 high current event not flagged");

   property p_ch2_temp;
      ch2_temp_over_low_in |=> alarm_q[SCF_FLG_CH2_TEMP_LOW];
   endproperty
   a_ch2_temp: assert property (p_ch2_temp)
      else $error("channel 2 low temperature event not flagged");

endmodule
`default_nettype wire

// *** hdl/scf_pkg.sv ***
package scf_pkg;
   localparam int unsigned SCF_DATA_W = 16;
   localparam int unsigned SCF_ALARM_W = 8;
   // software clear control bit positions
   localparam int unsigned SCF_CLR_COMPLETE_RESET_CMD = 6;
   localparam int unsigned SCF_CLR_COMPLETE_RESET_ARM = 5;
   localparam int unsigned SCF_CLR_ALARM_THRESHOLD = 4;
   localparam int unsigned SCF_CLR_AVERAGING_MEMORY = 3;
   localparam int unsigned SCF_CLR_SAMPLE_QUEUE = 2;
   localparam int unsigned SCF_CLR_CH2_CONVERTER = 1;
   localparam int unsigned SCF_CLR_CH1_CONVERTER = 0;
   // status flag bit positions
   localparam int unsigned SCF_FLG_ALU_BUSY = 11;
   localparam int unsigned SCF_FLG_RESTART = 10;
   localparam int unsigned SCF_FLG_QUEUE_EMPTY = 9;
   localparam int unsigned SCF_FLG_QUEUE_OVERFLOW = 8;
   localparam int unsigned SCF_FLG_CH2_CURRENT_HIGH = 7;
   localparam int unsigned SCF_FLG_CH2_CURRENT_LOW = 6;
   localparam int unsigned SCF_FLG_CH2_TEMP_HIGH = 5;
   localparam int unsigned SCF_FLG_CH2_TEMP_LOW = 4;
   localparam int unsigned SCF_FLG_CH1_CURRENT_HIGH = 3;
   localparam int unsigned SCF_FLG_CH1_CURRENT_LOW = 2;
   localparam int unsigned SCF_FLG_CH1_TEMP_HIGH = 1;
   localparam int unsigned SCF_FLG_CH1_TEMP_LOW = 0;
   localparam int unsigned SCF_FLG_RSVD_LSB = 12;
   // reset values
   localparam logic SCF_ARM_RST = 1'b0;
   localparam logic SCF_PULSE_RST = 1'b0;
   localparam logic SCF_RESTART_RST = 1'b0;
   localparam logic SCF_OVERFLOW_RST = 1'b0;
   localparam logic [SCF_ALARM_W-1:0] SCF_ALARM_RST = 8'h00;
   localparam logic [SCF_DATA_W-1:0] SCF_WORD_RST = 16'h0000;
   localparam logic [3:0] SCF_RSVD_VALUE = 4'h0;
   // tag placed in the upper nibble of a read from an empty queue
   localparam logic [3:0] SCF_EMPTY_QUEUE_TAG = 4'hF;
endpackage

// *** tb/scf_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module scf_host_model (
   input wire logic clk_in,
   output logic clr_wr_out,
   output logic [15:0] clr_wdata_out,
   output logic flag_rd_out,
   output logic queue_empty_rd_out
);
   initial begin
      clr_wr_out = 1'b0;
      clr_wdata_out = 16'h0000;
      flag_rd_out = 1'b0;
      queue_empty_rd_out = 1'b0;
   end
   // k picks the strobe: 0 clear write, 1 status read, 2 empty queue read
   task automatic xfer(input int k, input logic [15:0] d);
      @(posedge clk_in);
      #1;
      clr_wr_out = (k == 0);
      clr_wdata_out = d;
      flag_rd_out = (k == 1);
      queue_empty_rd_out = (k == 2);
      @(posedge clk_in);
      #1;
      clr_wr_out = 1'b0;
      flag_rd_out = 1'b0;
      queue_empty_rd_out = 1'b0;
      // scrambled once released, so nothing leans on a stale word
      clr_wdata_out = ~d;
   endtask
   task automatic arm_and_fire;
      xfer(0, 16'h0020);
      xfer(0, 16'h0040);
   endtask
   // in die temperature mode the channel 2 temperature bits mean nothing
   function automatic logic [15:0] mask_view(input logic [15:0] w, input logic die);
      return die ? (w & 16'hFFCF) : w;
   endfunction
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import scf_pkg::*;
   logic clk, srst, busy, emp, ovf, full, wout, strm, die, dh, dl, cw, fr, er, wp, rp, ep;
   logic c6, c4, c3, c2, c1, c0, arm_m, rs_m, mp;
   logic [7:0] ev;
   logic [15:0] wd, fd, ed, pv, d;
   logic [15:0] expq[$];
   int failures, checks, i;
   integer seed;
   scf_host_model host (.clk_in(clk), .clr_wr_out(cw), .clr_wdata_out(wd), .flag_rd_out(fr),
      .queue_empty_rd_out(er));
   scf_soft_clear_and_flag_status dut (.core_clk_in(clk), .srst_in(srst), .clr_wr_in(cw),
      .clr_wdata_in(wd), .flag_rd_in(fr), .flag_rdata_out(fd), .queue_empty_rd_in(er),
      .queue_empty_word_out(ed), .alu_busy_in(busy), .queue_is_empty_in(emp),
      .queue_overflow_in(ovf), .queue_is_full_in(full), .queue_word_out_in(wout),
      .lut_stream_mode_in(strm), .die_temp_on_second_channel_in(die),
      .die_temp_alarm_high_in(dh), .die_temp_alarm_low_in(dl),
      .ch2_current_over_high_in(ev[7]), .ch2_current_over_low_in(ev[6]),
      .ch2_temp_over_high_in(ev[5]), .ch2_temp_over_low_in(ev[4]),
      .ch1_current_over_high_in(ev[3]), .ch1_current_over_low_in(ev[2]),
      .ch1_temp_over_high_in(ev[1]), .ch1_temp_over_low_in(ev[0]),
      .complete_reset_out(c6), .alarm_threshold_clear_out(c4),
      .averaging_memory_clear_out(c3), .sample_queue_clear_out(c2),
      .ch2_converter_clear_out(c1), .ch1_converter_clear_out(c0));
   // pulses laid out on the bit positions of the write word
   assign pv = {9'h000, c6, 1'b0, c4, c3, c2, c1, c0};
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic logic [15:0] st(input logic r, input logic o, input logic [7:0] a);
      return {4'h0, busy, r, emp, o, a};
   endfunction
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] w, input logic [15:0] e);
      expq.push_back(e);
      host.xfer(0, w);
   endtask
   task automatic rd(input logic [15:0] e);
      expq.push_back(e);
      host.xfer(1, 16'h0000);
   endtask
   always @(posedge clk) begin
      wp <= cw;
      rp <= fr;
      ep <= er;
      mp <= die;
   end
   // results are settled by the falling edge after the taking edge
   always @(negedge clk) begin
      logic [15:0] e;
      if (!srst) begin
         if (wp || rp || ep) e = expq.pop_front();
         if (wp) chk(pv, e, "clear pulses");
         else chk(pv, 16'h0000, "idle pulses");
         if (rp) chk(host.mask_view(fd, mp), host.mask_view(e, mp), "status");
         if (ep) chk(ed, e, "empty queue word");
      end
   end
   initial begin
      #200us;
      failures++;
      report_and_stop();
   end
   initial begin
      {busy, ovf, full, wout, strm, die, dh, dl, ev} = '0;
      {srst, emp, arm_m, rs_m} = 4'b1100;
      seed = 32'h8511F04B;
      repeat (6) @(posedge clk);
      #1;
      srst = 1'b0;
      rd(st(0, 0, 0));
      for (i = 0; i < 12; i++) begin
         d = 16'($random(seed));
         wr(d, (d & 16'h001F) | ((d[6] && arm_m) ? 16'h0040 : 16'h0000));
         rs_m = rs_m | (d[6] & arm_m);
         arm_m = d[5] & ~d[6];
      end
      rd(st(rs_m, 0, 0));
      wr(16'h0000, 16'h0000);
      wr(16'h0040, 16'h0000);
      wr(16'h0020, 16'h0000);
      wr(16'h0001, 16'h0001);
      wr(16'h0040, 16'h0000);
      ev = 8'hA5;
      tick;
      ev = 8'h00;
      expq.push_back(16'h0000);
      expq.push_back(16'h0040);
      host.arm_and_fire();
      rd(st(1, 0, 0));
      rd(st(0, 0, 0));
      for (i = 0; i < 4; i++) begin
         d = 16'($random(seed));
         ev = d[7:0];
         tick;
         ev = 8'h00;
         expq.push_back(16'hF000 | st(0, 0, d[7:0]));
         host.xfer(2, 16'h0000);
         rd(st(0, 0, d[7:0]));
         rd(st(0, 0, 0));
      end
      ev = 8'hFF;
      tick;
      ev = 8'h00;
      wr(16'h0010, 16'h0010);
      rd(st(0, 0, 0));
      {busy, emp, ovf} = 3'b101;
      tick;
      ovf = 1'b0;
      rd(st(0, 1, 0));
      rd(st(0, 0, 0));
      {busy, strm, full} = 3'b011;
      rd(st(0, 1, 0));
      rd(st(0, 1, 0));
      {full, wout} = 2'b01;
      tick;
      wout = 1'b0;
      rd(st(0, 0, 0));
      // ch2 current events must be ignored and ch2 temperature bits are masked
      {strm, die, dh, dl} = 4'b0110;
      ev = 8'hF0;
      tick;
      {dh, dl} = 2'b00;
      ev = 8'h00;
      rd(st(0, 0, 8'h80));
      die = 1'b0;
      fork
         rd(st(0, 0, 0));
         begin
            tick;
            ev = 8'h04;
            tick;
            ev = 8'h00;
         end
      join
      rd(st(0, 0, 8'h04));
      tick;
      report_and_stop();
   end
endmodule
`default_nettype wire
